// *** core/pmx_pkg.sv ***
// constants for the channel 0 transmit data bit 1 input multiplexer
// assumes a single 20 MHz system clock; no software-visible registers
package pmx_pkg;

  // system clock period in ns
  localparam int unsigned SYS_CLK_PERIOD_NS = 50;

  // half period of the hdlc byte clock we drive, in ns
  localparam int unsigned HDLC_HALF_NS = 100;

  // least time, so round the cycle count up; never below one cycle
  localparam int unsigned HDLC_HALF_RAW =
    (HDLC_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int unsigned HDLC_HALF_CYCLES = (HDLC_HALF_RAW < 1) ? 1 : HDLC_HALF_RAW;

  // width of the half-period counter
  localparam int unsigned HDLC_CNT_W = 8;

  // reset values
  localparam logic RST_BIT = 1'h0;
  localparam logic [7:0] RST_CNT = 8'h00;

  // channel role when the add bus is disabled
  typedef enum logic [1:0] {
    PMX_MODE_IDLE = 2'h0,  // no consumer of the pin
    PMX_MODE_HDLC = 2'h1,  // high-speed hdlc byte bus
    PMX_MODE_ATM  = 2'h3   // atm uni gfc data
  } pmx_mode_e;

endpackage : pmx_pkg

// *** core/pmx_smp_if.sv ***
// carrier between the multiplexer top and its edge samplers
// assumes both ends share sys_clk
`timescale 1ns/1ps
interface pmx_smp_if;
  logic en;       // sampler may capture
  logic ref_lvl;  // clock level whose edge triggers capture
  logic din;      // shared pin level
  logic q;        // captured bit
  logic stb;      // one-cycle capture pulse

  // the sampler end
  modport sampler (
    input  en,
    input  ref_lvl,
    input  din,
    output q,
    output stb
  );

  // the user end
  modport user (
    output en,
    output ref_lvl,
    output din,
    input  q,
    input  stb
  );
endinterface : pmx_smp_if

// *** core/pmx_sampler.sv ***
// edge-triggered single bit capture, rising or falling by parameter
// assumes ref_lvl and din are synchronous to sys_clk
`timescale 1ns/1ps
module pmx_sampler #(
  parameter bit RISE = 1'h1  // 1: capture on rising edge, 0: on falling edge
) (
  // clock and reset
  input wire logic    sys_clk,
  input wire logic    rstn,
  // carrier
  pmx_smp_if.sampler  smp
);

  // whole sampler state
  typedef struct packed {
    logic prev;  // reference level one cycle ago
    logic q;     // captured bit
    logic stb;   // capture pulse
  } pmx_smp_s;

  pmx_smp_s st;       // registered state
  pmx_smp_s next_st;  // next state
  logic     edge_hit; // reference edge seen this cycle

  // edge detect and capture
  always_comb begin
    next_st      = st;
    next_st.prev = smp.ref_lvl;
    next_st.stb  = 1'h0;
    // edge is judged against our own copy, never an async stage
    edge_hit     = RISE ? (smp.ref_lvl & ~st.prev) : (~smp.ref_lvl & st.prev);
    if (smp.en && edge_hit) begin
      next_st.q   = smp.din;
      next_st.stb = 1'h1;
    end
  end

  // state register, synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign smp.q   = st.q;
  assign smp.stb = st.stb;

  // every enabled edge brings a capture, which holds the pin level of that cycle
  AST_SMP_CAPTURE: assert property (@(posedge sys_clk) disable iff (!rstn) // see R05
    (smp.en && edge_hit) |=> (smp.stb && smp.q == $past(smp.din)))
    else $error("sampler missed an enabled edge");

endmodule : pmx_sampler

// *** core/pmx_top.sv ***
// channel 0 transmit data bit 1 input multiplexer
// assumes all pins synchronous to sys_clk; mode straps held steady by system
//
// Functional notes
// R01 - pin role follows add bus enable
// R02 - add bus: bit 1, falling add clock
// R03 - hdlc mode: bit 1 of byte bus
// R04 - hdlc mode: drive byte clock output
// R05 - hdlc: capture on rising own clock
// R06 - atm mode only: pin is gfc data
// R07 - add bus enabled: hdlc and gfc ignored
`timescale 1ns/1ps
module pmx_top #(
  parameter int unsigned HALF_CYCLES = pmx_pkg::HDLC_HALF_CYCLES  // hdlc clock half period
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // configuration
  input  wire logic       add_bus_en,        // add-side telecom bus enabled
  input  wire logic [1:0] chan_mode,         // pmx_mode_e when add bus disabled
  // shared pin and add bus clock
  input  wire logic       shared_pin,        // the multiplexed data input
  input  wire logic       add_bus_clock_ch0, // add bus clock, sampled
  // add bus consumer
  output logic            add_bus_ch0_bit1,  // captured add bus bit 1
  output logic            add_bus_strobe,    // one-cycle capture pulse
  // hdlc consumer
  output logic            hdlc_tx_byte_clock_ch0, // byte clock we drive
  output logic            hdlc_tx_data_ch0_bit1,  // captured hdlc bit 1
  output logic            hdlc_strobe,            // one-cycle capture pulse
  // atm gfc consumer
  output logic            gfc_tx_data_ch0,   // registered gfc bit
  output logic            gfc_valid          // gfc bit is live
);

  // last count value before the byte clock flips
  localparam logic [pmx_pkg::HDLC_CNT_W-1:0] CNT_LAST =
    pmx_pkg::HDLC_CNT_W'(HALF_CYCLES - 1);

  // whole top-level state
  typedef struct packed {
    logic [pmx_pkg::HDLC_CNT_W-1:0] cnt;      // half-period counter
    logic                           hdlc_clk; // driven byte clock
    logic                           gfc;      // gfc bit
    logic                           gfc_vld;  // gfc valid
  } pmx_top_s;

  pmx_top_s st;       // registered state
  pmx_top_s next_st;  // next state

  logic hdlc_act;  // hdlc role owns the pin
  logic atm_act;   // gfc role owns the pin

  // role decode: add bus wins over any mode setting
  always_comb begin
    hdlc_act = ~add_bus_en && (chan_mode == pmx_pkg::PMX_MODE_HDLC); // see R01 see R07
    atm_act  = ~add_bus_en && (chan_mode == pmx_pkg::PMX_MODE_ATM);  // see R06 see R07
  end

  // carriers to the two samplers
  pmx_smp_if add_if ();
  pmx_smp_if hdlc_if ();

  // add bus sampler, falling edge of the add clock
  assign add_if.en      = add_bus_en;        // see R02
  assign add_if.ref_lvl = add_bus_clock_ch0;
  assign add_if.din     = shared_pin;

  // hdlc sampler, rising edge of our own byte clock
  assign hdlc_if.en      = hdlc_act;         // see R03
  assign hdlc_if.ref_lvl = st.hdlc_clk;      // see R05
  assign hdlc_if.din     = shared_pin;

  pmx_sampler #(
    .RISE (1'h0)
  ) u_add_smp (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .smp     (add_if.sampler)
  );

  pmx_sampler #(
    .RISE (1'h1)
  ) u_hdlc_smp (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .smp     (hdlc_if.sampler)
  );

  // divider for the byte clock and the gfc path
  always_comb begin
    next_st = st;
    if (hdlc_act) begin
      // free-running square wave while hdlc owns the pin
      if (st.cnt == CNT_LAST) begin
        next_st.cnt      = '0;
        next_st.hdlc_clk = ~st.hdlc_clk;          // see R04
      end else begin
        next_st.cnt = st.cnt + 1'h1;
      end
    end else begin
      // parked low so the next start begins with a clean rising edge
      next_st.cnt      = '0;
      next_st.hdlc_clk = 1'h0;                    // see R07
    end
    // gfc simply follows the pin; framing of gfc bits lives elsewhere
    next_st.gfc_vld = atm_act;                    // see R06
    next_st.gfc     = atm_act ? shared_pin : 1'h0;
  end

  // state register, synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st.cnt      <= pmx_pkg::RST_CNT;
      st.hdlc_clk <= pmx_pkg::RST_BIT;
      st.gfc      <= pmx_pkg::RST_BIT;
      st.gfc_vld  <= pmx_pkg::RST_BIT;
    end else begin
      st <= next_st;
    end
  end

  // outputs, each straight from a flip-flop
  assign add_bus_ch0_bit1       = add_if.q;
  assign add_bus_strobe         = add_if.stb;
  assign hdlc_tx_byte_clock_ch0 = st.hdlc_clk;
  assign hdlc_tx_data_ch0_bit1  = hdlc_if.q;
  assign hdlc_strobe            = hdlc_if.stb;
  assign gfc_tx_data_ch0        = st.gfc;
  assign gfc_valid              = st.gfc_vld;

  // named steps of an add bus capture
  sequence s_add_fall;
    (add_bus_en && add_bus_clock_ch0) ##1 (add_bus_en && !add_bus_clock_ch0);
  endsequence

  // named steps of an hdlc capture
  sequence s_hdlc_rise;
    hdlc_act && $rose(hdlc_tx_byte_clock_ch0);
  endsequence

  // add strobe only ever follows an enabled add bus
  AST_ROLE_SELECT: assert property (@(posedge sys_clk) disable iff (!rstn) // see R01
    add_bus_strobe |-> $past(add_bus_en))
    else $error("add bus capture while add bus disabled");

  // falling add clock captures the pin of that cycle
  AST_ADD_FALL: assert property (@(posedge sys_clk) disable iff (!rstn) // see R02
    s_add_fall |=> (add_bus_strobe && add_bus_ch0_bit1 == $past(shared_pin)))
    else $error("add bus bit not captured on falling clock");

  // hdlc strobe only in hdlc mode with add bus off
  AST_HDLC_ROLE: assert property (@(posedge sys_clk) disable iff (!rstn) // see R03
    hdlc_strobe |-> $past(hdlc_act))
    else $error("hdlc capture outside hdlc mode");

  // byte clock flips after the half period while hdlc is active
  AST_HDLC_CLK_FLIP: assert property (@(posedge sys_clk) disable iff (!rstn) // see R04
    (hdlc_act && st.cnt == CNT_LAST) ##1 hdlc_act
      |-> hdlc_tx_byte_clock_ch0 != $past(hdlc_tx_byte_clock_ch0))
    else $error("hdlc byte clock did not toggle");

  // rising byte clock captures the pin one cycle later
  AST_HDLC_RISE: assert property (@(posedge sys_clk) disable iff (!rstn) // see R05
    s_hdlc_rise |=> (hdlc_strobe && hdlc_tx_data_ch0_bit1 == $past(shared_pin)))
    else $error("hdlc bit not captured on rising byte clock");

  // gfc is live exactly in atm mode and mirrors the pin
  AST_GFC_ATM: assert property (@(posedge sys_clk) disable iff (!rstn) // see R06
    atm_act |=> (gfc_valid && gfc_tx_data_ch0 == $past(shared_pin)))
    else $error("gfc not following pin in atm mode");

  AST_GFC_ONLY: assert property (@(posedge sys_clk) disable iff (!rstn) // see R06
    gfc_valid |-> $past(atm_act))
    else $error("gfc valid outside atm mode");

  // enabled add bus silences the other two consumers
  AST_ADD_EXCL: assert property (@(posedge sys_clk) disable iff (!rstn) // see R07
    add_bus_en ##1 add_bus_en |-> (!hdlc_strobe && !gfc_valid && !hdlc_tx_byte_clock_ch0))
    else $error("hdlc or gfc active while add bus enabled");

  // named step of a byte clock phase that has not reached its end
  sequence s_hdlc_mid_phase;
    (hdlc_act && st.cnt != CNT_LAST) ##1 hdlc_act;
  endsequence

  // byte clock keeps its level inside a half period
  AST_HDLC_CLK_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn) // see R04
    s_hdlc_mid_phase |-> $stable(hdlc_tx_byte_clock_ch0))
    else $error("hdlc byte clock moved inside a half period");

  // any flip while active comes from the last count value
  AST_HDLC_FLIP_END: assert property (@(posedge sys_clk) disable iff (!rstn) // see R04
    ($changed(hdlc_tx_byte_clock_ch0) && $past(hdlc_act)) |-> $past(st.cnt) == CNT_LAST)
    else $error("hdlc byte clock flipped before the half period ended");

  // the counter never passes its last value
  AST_HDLC_CNT_RANGE: assert property (@(posedge sys_clk) disable iff (!rstn) // see R04
    st.cnt <= CNT_LAST)
    else $error("hdlc half-period counter out of range");

  // outside hdlc the byte clock is parked low with a cleared counter
  AST_HDLC_PARK: assert property (@(posedge sys_clk) disable iff (!rstn) // see R07
    !hdlc_act |=> (!hdlc_tx_byte_clock_ch0 && st.cnt == '0))
    else $error("hdlc byte clock not parked outside hdlc mode");

  // captured bits only change with their strobe; the cycle after reset is skipped
  AST_ADD_BIT_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn) // see R02
    ($past(rstn) && !add_bus_strobe) |-> $stable(add_bus_ch0_bit1))
    else $error("add bus bit changed without a capture");

  AST_HDLC_BIT_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn) // see R05
    ($past(rstn) && !hdlc_strobe) |-> $stable(hdlc_tx_data_ch0_bit1))
    else $error("hdlc bit changed without a capture");

  // capture pulses stand one cycle only, so a consumer never counts one twice
  AST_ADD_STB_ONE: assert property (@(posedge sys_clk) disable iff (!rstn) // see R02
    add_bus_strobe |=> !add_bus_strobe)
    else $error("add bus strobe stood two cycles");

  AST_HDLC_STB_ONE: assert property (@(posedge sys_clk) disable iff (!rstn) // see R05
    hdlc_strobe |=> !hdlc_strobe)
    else $error("hdlc strobe stood two cycles");

  // gfc data reads zero whenever gfc is not live
  AST_GFC_ZERO: assert property (@(posedge sys_clk) disable iff (!rstn) // see R06
    !gfc_valid |-> !gfc_tx_data_ch0)
    else $error("gfc data set while gfc not live");

endmodule : pmx_top

// *** test/pmx_partner.sv ***
// system-side equipment behind the shared channel 0 data input
// assumes it sees the device's byte clock and the strap levels
`timescale 1ns/1ps
module pmx_partner (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // straps and device clock
  input  wire logic       add_bus_en,
  input  wire logic [1:0] chan_mode,
  input  wire logic       hdlc_tx_byte_clock_ch0,
  // driven toward the device
  output logic            shared_pin,
  output logic            add_bus_clock_ch0
);
  int unsigned hold;  // cycles left in add clock phase
  logic        hc_q;  // byte clock at previous edge

  initial begin
    shared_pin = 1'h0;
    add_bus_clock_ch0 = 1'h0;
    hold = 2;
    hc_q = 1'b0;
  end

  // add clock with random phase lengths, data follows the mode
  always @(posedge sys_clk) begin
    hc_q <= hdlc_tx_byte_clock_ch0;
    if (!rstn) begin
      add_bus_clock_ch0 <= 1'h0;  // quiet in reset, so no stale fall
    end else if (hold > 1) begin
      hold <= hold - 1;
    end else begin
      hold <= 2 + $urandom % 3;  // prompt and slow phases
      add_bus_clock_ch0 <= ~add_bus_clock_ch0;
      if (add_bus_en && !add_bus_clock_ch0) begin
        shared_pin <= 1'($urandom);  // new bit with rise, stable over fall
      end
    end
    if (!add_bus_en && chan_mode == 2'h1) begin
      // byte clock just fell: new bit well clear of the rise
      if (hc_q && !hdlc_tx_byte_clock_ch0) begin
        shared_pin <= 1'($urandom);
      end
    end else if (!add_bus_en) begin
      shared_pin <= 1'($urandom);  // free-running level
    end
  end
endmodule : pmx_partner

// *** test/pmx_top_tb.sv ***
// self-checking bench: integer model against pmx_top at every cycle
// assumes pmx_pkg, pmx_smp_if, pmx_sampler and pmx_top compiled first
`timescale 1ns/1ps
`define CHK(a, e) begin \
  n_tests++; \
  if ((a) !== (e)) begin \
    errors++; \
    $display("CHECK FAILED at %0t ns: output differs from model", $time); \
  end \
end
module pmx_top_tb;
  localparam int unsigned HALF = 3;  // lengthened byte clock half period
  logic        sys_clk, rstn, add_bus_en, shared_pin, add_clk;
  logic [1:0]  chan_mode;
  logic        ab, as, hc, hb, hs, gd, gv;  // design outputs
  logic        e_ab, e_as, e_hc, e_hb, e_hs, e_gd, e_gv;  // model outputs
  logic        p_ac, p_hc, act_h, act_a;  // model history
  int unsigned cnt;  // model half-period counter
  int          errors, n_tests;
  logic [2:0]  cfg [6] = '{3'h5, 3'h1, 3'h3, 3'h0, 3'h2, 3'h7};

  pmx_top #(.HALF_CYCLES(HALF)) uut (
    .sys_clk(sys_clk), .rstn(rstn), .add_bus_en(add_bus_en), .chan_mode(chan_mode),
    .shared_pin(shared_pin), .add_bus_clock_ch0(add_clk), .add_bus_ch0_bit1(ab),
    .add_bus_strobe(as), .hdlc_tx_byte_clock_ch0(hc), .hdlc_tx_data_ch0_bit1(hb),
    .hdlc_strobe(hs), .gfc_tx_data_ch0(gd), .gfc_valid(gv)
  );

  pmx_partner sys_side (
    .sys_clk(sys_clk), .rstn(rstn), .add_bus_en(add_bus_en), .chan_mode(chan_mode),
    .hdlc_tx_byte_clock_ch0(hc), .shared_pin(shared_pin), .add_bus_clock_ch0(add_clk)
  );

  // 50 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // model, reading the levels seen at the edge
  always @(posedge sys_clk) begin
    act_h = !add_bus_en && chan_mode == 2'h1;
    act_a = !add_bus_en && chan_mode == 2'h3;
    if (!rstn) begin
      {e_ab, e_as, e_hc, e_hb, e_hs, e_gd, e_gv, p_hc} = '0;
      cnt = 0;
    end else begin
      e_as = add_bus_en && p_ac && !add_clk;  // falling add clock only
      if (e_as) e_ab = shared_pin;
      e_hs = act_h && e_hc && !p_hc;  // rising byte clock only
      if (e_hs) e_hb = shared_pin;
      p_hc = e_hc;
      if (!act_h) begin
        cnt = 0;
        e_hc = 1'h0;
      end else if (cnt == HALF - 1) begin
        cnt = 0;
        e_hc = !e_hc;
      end else begin
        cnt++;
      end
      e_gv = act_a;
      e_gd = act_a & shared_pin;
    end
    p_ac = add_clk;
  end

  // compare away from the edge, once everything has settled
  always @(negedge sys_clk) begin
    `CHK(ab, e_ab)
    `CHK(as, e_as)
    `CHK(hc, e_hc)
    `CHK(hb, e_hb)
    `CHK(hs, e_hs)
    `CHK(gd, e_gd)
    `CHK(gv, e_gv)
  end

  // verdict and end of run
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // hang guard
  initial begin
    #2000000;
    errors++;
    give_verdict();
  end

  // six of the eight strap settings, each after its own reset; straps idle while in reset
  initial begin
    errors = 0;
    n_tests = 0;
    void'($urandom(35));
    for (int i = 0; i < 6; i++) begin
      rstn <= 1'h0;
      add_bus_en <= 1'h0;
      chan_mode <= 2'h0;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'h1;
      @(posedge sys_clk);
      {add_bus_en, chan_mode} <= cfg[i];
      repeat (90) @(posedge sys_clk);
      $display("test %0d done: add bus %0b mode %0d", i, add_bus_en, chan_mode);
    end
    give_verdict();
  end
endmodule : pmx_top_tb
